//--- hw/fcs_pkg.sv
// Constants and types for the dual-bank NOR flash command sequencer host
package fcs_pkg;
   // Bus widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   // Clock and timing
   localparam int CLK_NS         = 100;
   localparam int STROBE_LOW_NS  = 200;
   localparam int STROBE_HIGH_NS = 200;
   localparam int READ_NS        = 300;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] STROBE_LOW_C  = 4'(STROBE_LOW_CYC);
   localparam logic [3:0] STROBE_HIGH_C = 4'(STROBE_HIGH_CYC);
   localparam logic [3:0] READ_C        = 4'(READ_CYC);
   // Unlock table, supplied from the device's standard command table
   localparam logic [19:0] UNLOCK_A1 = 20'h00555;
   localparam logic [19:0] UNLOCK_A2 = 20'h002AA;
   localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
   localparam logic [15:0] UNLOCK_D2 = 16'h0055;
   localparam logic [15:0] CMD_PROG  = 16'h00A0;
   localparam logic [15:0] CMD_ERASE = 16'h0080;
   // Final erase commands
   localparam logic [15:0] CMD_SECTOR = 16'h0050;
   localparam logic [15:0] CMD_BLOCK  = 16'h0030;
   localparam logic [15:0] CMD_CHIP   = 16'h0010;
   localparam logic [19:0] CHIP_ADDR  = 20'h00555;
   // Status bit positions
   localparam int INV_DATA_BIT = 7;
   localparam int TOGGLE_BIT   = 6;
   // Operation codes at the user port
   typedef enum logic [2:0] {
      FCS_OP_READ   = 3'h0,
      FCS_OP_PROG   = 3'h1,
      FCS_OP_SECTOR = 3'h2,
      FCS_OP_BLOCK  = 3'h3,
      FCS_OP_CHIP   = 3'h4
   } fcs_op_t;
   // Sequencer states, gray along the write path except the return from polling to idle
   typedef enum logic [2:0] {
      FCS_IDLE  = 3'b000,
      FCS_SETUP = 3'b001,
      FCS_LOW   = 3'b011,
      FCS_HIGH  = 3'b010,
      FCS_POLL  = 3'b110,
      FCS_READ  = 3'b111
   } fcs_state_t;
endpackage

//--- hw/fcs_host.sv
// Host controller driving a dual-bank NOR flash through its pins
// Function
// - Write: strobe write low under chip select
// - Program: three unlock cycles, then data
// - Sector erase: six cycles, 50H last
// - Block erase: six cycles, 30H last
// - Chip erase: six cycles, 10H at 555H
// - Status only from busy bank
`timescale 1ns/1ns
module fcs_host
   import fcs_pkg::*;
(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_b,
   // User request
   input  wire logic                    req_valid,
   output wire logic                    req_ready,
   input  wire fcs_pkg::fcs_op_t        req_op,
   input  wire logic [fcs_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [fcs_pkg::DATA_W-1:0] req_data,
   input  wire logic                    byte_mode,
   input  wire logic                    flash_reset_req,
   // User answer
   output logic                         done,
   output logic                         rd_valid,
   output logic [fcs_pkg::DATA_W-1:0]   rd_data,
   // Flash pins
   output logic                         chip_sel_n,
   output logic                         write_n,
   output logic                         out_en_n,
   output logic                         flash_rst_n,
   output logic                         byte_n,
   output logic [fcs_pkg::ADDR_W-1:0]   addr,
   output logic [fcs_pkg::DATA_W-1:0]   dq_o,
   output logic                         dq_oe,
   input  wire logic [fcs_pkg::DATA_W-1:0] dq_i,
   input  wire logic                    done_flag_n
);
   import fcs_pkg::*;

   fcs_state_t         state_r, state_nxt; // Sequencer state
   fcs_op_t            op_r;               // Captured operation
   logic [2:0]         cyc_r;              // Bus cycle index in sequence
   logic [3:0]         cnt_r;              // Strobe timing counter
   logic [ADDR_W-1:0]  taddr_r;            // Target address
   logic [DATA_W-1:0]  tdata_r;            // Target data
   logic               tog_prev_r;         // Previous toggle bit sample
   logic               first_poll_r;       // No earlier poll sample yet
   logic [DATA_W-1:0]  dq_s1_r, dq_s2_r;   // Data synchroniser
   logic               rb_s1_r, rb_s2_r;   // Done flag synchroniser

   // Number of bus cycles in the sequence
   function automatic logic [2:0] seq_len(input fcs_op_t op);
      seq_len = (op == FCS_OP_PROG) ? 3'd4 : 3'd6;
   endfunction

   // Address and data for one cycle of a command sequence
   function automatic logic [35:0] seq_word(input fcs_op_t op,
      input logic [2:0] c, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      logic [15:0] last_cmd;
      last_cmd = (op == FCS_OP_SECTOR) ? CMD_SECTOR :
                 (op == FCS_OP_BLOCK)  ? CMD_BLOCK  : CMD_CHIP;
      case (c)
         3'd0, 3'd3: seq_word = {UNLOCK_A1, UNLOCK_D1};
         3'd1, 3'd4: seq_word = {UNLOCK_A2, UNLOCK_D2};
         3'd2: seq_word = {UNLOCK_A1,
                           (op == FCS_OP_PROG) ? CMD_PROG : CMD_ERASE};
         default: begin
            if (op == FCS_OP_CHIP)
               seq_word = {CHIP_ADDR, CMD_CHIP};
            else if (op == FCS_OP_PROG)
               seq_word = {a, d};
            else
               seq_word = {a, last_cmd};
         end
      endcase
      // Program's fourth cycle is index 3
      if (op == FCS_OP_PROG && c == 3'd3)
         seq_word = {a, d};
   endfunction

   wire        is_write   = (op_r != FCS_OP_READ);
   wire [2:0]  nxt_cyc    = (state_r == FCS_HIGH) ? cyc_r + 3'd1 : cyc_r;
   wire [35:0] cur_word   = seq_word(op_r, nxt_cyc, taddr_r, tdata_r);
   wire        last_cyc   = (cyc_r == seq_len(op_r) - 3'd1);
   wire        cnt_done   = (cnt_r == 4'h1);
   wire        busy_pin   = ~rb_s2_r;
   // Polling finishes when toggle bit stops and done flag is high
   wire        tog_stable = (dq_s2_r[TOGGLE_BIT] == tog_prev_r);
   wire        poll_done  = ~first_poll_r & tog_stable & ~busy_pin;

   assign req_ready = (state_r == FCS_IDLE);

   // Two flops on all inputs from the flash
   always_ff @(posedge core_clk) begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= done_flag_n;
      rb_s2_r <= rb_s1_r;
   end

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FCS_IDLE:  if (req_valid) state_nxt = FCS_SETUP;
         FCS_SETUP: state_nxt = is_write ? FCS_LOW : FCS_READ;
         FCS_LOW:   if (cnt_done) state_nxt = FCS_HIGH;
         FCS_HIGH: begin
            if (cnt_done)
               state_nxt = last_cyc ? FCS_POLL : FCS_LOW;
         end
         FCS_POLL:  if (cnt_done && poll_done) state_nxt = FCS_IDLE;
         FCS_READ:  if (cnt_done) state_nxt = FCS_IDLE;
         default:   state_nxt = FCS_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_r      <= FCS_IDLE;
         op_r         <= FCS_OP_READ;
         cyc_r        <= 3'd0;
         cnt_r        <= 4'h0;
         taddr_r      <= '0;
         tdata_r      <= '0;
         tog_prev_r   <= 1'b0;
         first_poll_r <= 1'b1;
         done         <= 1'b0;
         rd_valid     <= 1'b0;
         rd_data      <= '0;
      end else begin
         state_r  <= state_nxt;
         done     <= 1'b0;
         rd_valid <= 1'b0;
         cnt_r    <= cnt_done ? 4'h0 : cnt_r - 4'h1;
         case (state_r)
            FCS_IDLE: begin
               // Chip erase under write protect would be dropped anyway
               if (req_valid) begin
                  op_r    <= req_op;
                  taddr_r <= req_addr;
                  tdata_r <= req_data;
               end
               cyc_r <= 3'd0;
            end
            FCS_SETUP: begin
               cnt_r        <= is_write ? STROBE_LOW_C : READ_C;
               first_poll_r <= 1'b1;
            end
            FCS_LOW: if (cnt_done) cnt_r <= STROBE_HIGH_C;
            FCS_HIGH: begin
               if (cnt_done) begin
                  cyc_r <= cyc_r + 3'd1;
                  cnt_r <= last_cyc ? READ_C : STROBE_LOW_C;
               end
            end
            FCS_POLL: begin
               // Sample status at the target, inside the busy bank
               if (cnt_done) begin
                  tog_prev_r   <= dq_s2_r[TOGGLE_BIT];
                  first_poll_r <= 1'b0;
                  cnt_r        <= READ_C + 4'h1; // Gap cycle
                  done         <= poll_done;
               end
            end
            FCS_READ: begin
               if (cnt_done) begin
                  rd_valid <= 1'b1;
                  rd_data  <= byte_mode ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
               end
            end
            default: ;
         endcase
      end
   end

   // Flash pin drive, registered
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         chip_sel_n  <= 1'b1;
         write_n     <= 1'b1;
         out_en_n    <= 1'b1;
         flash_rst_n <= 1'b0;
         byte_n      <= 1'b1;
         addr        <= '0;
         dq_o        <= '0;
         dq_oe       <= 1'b0;
      end else begin
         flash_rst_n <= ~flash_reset_req;
         byte_n      <= ~byte_mode;
         // Chip select held low across the strobe
         chip_sel_n  <= ~(state_nxt == FCS_LOW || state_nxt == FCS_HIGH ||
                          state_nxt == FCS_POLL || state_nxt == FCS_READ);
         write_n     <= ~(state_nxt == FCS_LOW);
         out_en_n    <= (state_r == FCS_POLL && cnt_done) |
                        ~(state_nxt == FCS_POLL || state_nxt == FCS_READ);
         dq_oe       <= (state_nxt == FCS_LOW || state_nxt == FCS_HIGH) &&
                        state_r != FCS_POLL;
         if (state_nxt == FCS_LOW) begin
            addr <= cur_word[35:16];
            dq_o <= cur_word[15:0];
         end else if (state_nxt == FCS_READ || state_nxt == FCS_POLL) begin
            addr <= taddr_r;
         end
      end
   end

   // Write strobe never low without chip select
   property p_strobe_sel;
      @(posedge core_clk) disable iff (!rst_b) !write_n |-> !chip_sel_n;
   endproperty
   a_strobe_sel: assert property (p_strobe_sel)
      else $error("write strobe low without chip select");

   // No bus contention with output enable
   property p_no_fight;
      @(posedge core_clk) disable iff (!rst_b) dq_oe |-> out_en_n;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("host drives data while flash output enabled");

   // Data stable while strobe low
   property p_data_hold;
      @(posedge core_clk) disable iff (!rst_b)
         (!write_n && $past(!write_n)) |-> $stable(dq_o) && $stable(addr);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("address or data moved during write strobe");

   // Strobe low lasts its count
   property p_low_len;
      @(posedge core_clk) disable iff (!rst_b)
         $fell(write_n) |-> !write_n [*2];
   endproperty
   a_low_len: assert property (p_low_len)
      else $error("write strobe pulse too short");

   // Done only after polling
   property p_done_poll;
      @(posedge core_clk) disable iff (!rst_b)
         done |-> $past(state_r) == FCS_POLL && !busy_pin;
   endproperty
   a_done_poll: assert property (p_done_poll)
      else $error("done raised outside polling or while busy");

   // Reset pin follows request
   property p_rst_pin;
      @(posedge core_clk) disable iff (!rst_b)
         flash_reset_req |=> !flash_rst_n;
   endproperty
   a_rst_pin: assert property (p_rst_pin)
      else $error("flash reset pin not asserted");

   // Last program cycle carries user data
   property p_prog_data;
      @(posedge core_clk) disable iff (!rst_b)
         ($fell(write_n) && op_r == FCS_OP_PROG && cyc_r == 3'd3)
            |-> dq_o == tdata_r && addr == taddr_r;
   endproperty
   a_prog_data: assert property (p_prog_data)
      else $error("program data cycle wrong");

   // Chip erase ends with its command at its address
   property p_chip_cmd;
      @(posedge core_clk) disable iff (!rst_b)
         ($fell(write_n) && op_r == FCS_OP_CHIP && cyc_r == 3'd5)
            |-> dq_o == CMD_CHIP && addr == CHIP_ADDR;
   endproperty
   a_chip_cmd: assert property (p_chip_cmd)
      else $error("chip erase final cycle wrong");

   c_prog:  cover property (@(posedge core_clk) done && op_r == FCS_OP_PROG);
   c_sect:  cover property (@(posedge core_clk) done && op_r == FCS_OP_SECTOR);
   c_read:  cover property (@(posedge core_clk) rd_valid);
   c_chip:  cover property (@(posedge core_clk) done && op_r == FCS_OP_CHIP);
endmodule

//--- testbench/fcs_flash_model.sv
// Behavioural dual-bank NOR flash, driven through its pins
`timescale 1ns/1ns
module fcs_flash_model #(
   parameter int PROG_NS  = 7000,  // Program time
   parameter int ERASE_NS = 20000  // Erase time, shortened for the run
) (
   // Bus strobes and pins
   input  wire logic        chip_sel_n,
   input  wire logic        write_n,
   input  wire logic        out_en_n,
   input  wire logic        rst_n,
   input  wire logic        byte_n,
   input  wire logic        wp_n,
   // Address and data
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_o,
   output wire logic [15:0] dq_i,
   output wire logic        done_flag_n
);
   logic [15:0] mem [0:20'hFFFFF];  // Word array
   logic [19:0] la, ba;             // Latched and busy addresses
   logic [15:0] pd, held;           // Program data, last driven value
   logic        busy, ers, tog, act, lp;
   int          cyc, bad, sh, nt;
   event        go;
   initial begin
      busy = 0; ers = 0; tog = 0; act = 0; lp = 1; cyc = 0; bad = 0; nt = 0;
      held = 16'h0000; pd = 16'h0000; ba = 20'h00000;
      foreach (mem[i]) mem[i] = 16'hFFFF;
   end
   // Command decode; the unlock pattern is the standard table
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      logic ok;
      if (busy) return;
      case (cyc)
         0, 5: ok = a == 20'h00555 && d[7:0] == 8'hAA;
         1, 6: ok = a == 20'h002AA && d[7:0] == 8'h55;
         2: ok = a == 20'h00555 && d[7:0] inside {8'hA0, 8'h80};
         3: ok = 1'b1;
         default: ok = d[7:0] inside {8'h50, 8'h30} ||
            (d[7:0] == 8'h10 && a == 20'h00555);
      endcase
      if (!ok) begin
         bad++;
         cyc = 0;
         return;
      end
      cyc = (cyc == 2 && d[7:0] == 8'h80) ? 5 : cyc + 1;
      if (cyc == 4) begin
         // Program one unit; flash only clears bits
         cyc = 0;
         if (!wp_n && a < 20'h02000) return;
         pd = d;
         mem[a] = mem[a] & (byte_n ? d : {8'hFF, d[7:0]});
         ers = 0; ba = a; -> go;
      end else if (cyc == 8) begin
         // Erase a 2K sector, a 32K block or everything
         cyc = 0;
         if (d[7:0] == 8'h10 && !wp_n) return;
         sh = d[7:0] == 8'h10 ? 20 : d[7:0] == 8'h50 ? 11 : 15;
         if (sh < 20 && !wp_n && a < 20'h02000) return;
         for (int i = (a >> sh) << sh; i < ((a >> sh) + 1) << sh; i++)
            mem[i] = 16'hFFFF;
         ers = 1; ba = a; -> go;
      end
   endtask
   // Address on the later fall, data on the earlier rise
   always @(negedge write_n or negedge chip_sel_n) begin
      #1; // Address moves on the same clock edge as the strobe
      if (!write_n && !chip_sel_n) begin
         la = addr;
         act = 1;
      end
   end
   always @(posedge write_n or posedge chip_sel_n)
      if (act) begin
         act = 0;
         wr(la, dq_o);
      end
   // Internal operation timer
   always @(go) begin
      busy = 1;
      #(ers ? ERASE_NS : PROG_NS);
      busy = 0;
   end
   // Reset pin drops a half-entered command
   always @(negedge rst_n) cyc = 0;
   // Low power after a read, woken by the next one
   always @(posedge out_en_n) lp = 1;
   always @(negedge out_en_n) begin
      lp = 0;
      if (busy) begin
         tog = ~tog;
         nt++;
      end
   end
   // Status only in the busy bank; upper lane shows address bits 15:8 in x8
   wire        same = (addr < 20'h40000) == (ba < 20'h40000);
   wire        drv  = !chip_sel_n && !out_en_n;
   wire [15:0] st   = {8'h00, ers ? 1'b0 : ~pd[7], tog, 6'h00};
   wire [15:0] arr  = byte_n ? mem[addr] : {addr[15:8], mem[addr][7:0]};
   wire [15:0] rdv  = busy && same ? st : arr;
   always @(rdv or drv) if (drv) held = rdv;
   // Released bus shows the inverse, not the old value
   assign dq_i = drv ? rdv : ~held;
   assign done_flag_n = !busy;
endmodule

//--- testbench/fcs_host_tb.sv
// Self-checking bench for the flash sequencer host
`timescale 1ns/1ns
module fcs_host_tb;
   import fcs_pkg::*;
   logic              core_clk, rst_b, req_valid, byte_mode, wp_n;
   logic              flash_reset_req, req_ready, done, rd_valid;
   logic              chip_sel_n, write_n, out_en_n, flash_rst_n, byte_n;
   logic              dq_oe, done_flag_n;
   fcs_op_t           req_op;
   logic [ADDR_W-1:0] req_addr, addr;
   logic [DATA_W-1:0] req_data, rd_data, dq_o, dq_i;
   int                miscompares, n_checks, cyc_cnt, took;
   fcs_host dut_u (.core_clk, .rst_b, .req_valid, .req_ready, .req_op,
      .req_addr, .req_data, .byte_mode, .flash_reset_req, .done,
      .rd_valid, .rd_data, .chip_sel_n, .write_n, .out_en_n,
      .flash_rst_n, .byte_n, .addr, .dq_o, .dq_oe, .dq_i, .done_flag_n);
   fcs_flash_model flash_u (.chip_sel_n, .write_n, .out_en_n,
      .rst_n(flash_rst_n), .byte_n, .wp_n, .addr, .dq_o, .dq_i,
      .done_flag_n);
   // Clock and hang guard
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         miscompares++;
         results();
      end
   end
   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One request; took counts cycles to its answer
   task automatic op(input fcs_op_t o, input logic [19:0] a,
                     input logic [15:0] d, input logic [15:0] exp);
      @(negedge core_clk);
      req_op = o; req_addr = a; req_data = d; req_valid = 1'b1;
      took = 0;
      while (req_ready !== 1'b1 && took < 50) @(negedge core_clk) took++;
      @(negedge core_clk);
      req_valid = 1'b0;
      took = 0;
      while (done !== 1'b1 && rd_valid !== 1'b1 && took < 1000) begin
         @(negedge core_clk);
         took++;
      end
      chk(16'(done | rd_valid), 16'h0001);
      if (o == FCS_OP_READ) chk(rd_data, exp);
   endtask
   // Verdict
   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      core_clk = 0; rst_b = 0; req_valid = 0; req_op = FCS_OP_READ;
      req_addr = '0; req_data = '0; byte_mode = 0; flash_reset_req = 0;
      wp_n = 1; miscompares = 0; n_checks = 0; cyc_cnt = 0;
      repeat (3) @(negedge core_clk);
      chk(16'({chip_sel_n, write_n, out_en_n, flash_rst_n, dq_oe}),
          16'h001C);
      rst_b = 1;
      op(FCS_OP_READ, 20'h12345, 16'h0000, 16'hFFFF);
      op(FCS_OP_PROG, 20'h40010, 16'h1234, 16'h0000);
      chk(16'(took >= 70), 16'h0001);
      chk(16'(flash_u.nt > 2), 16'h0001);
      op(FCS_OP_PROG, 20'h40810, 16'h0F0F, 16'h0000);
      op(FCS_OP_READ, 20'h40010, 16'h0000, 16'h1234);
      wp_n = 0;
      op(FCS_OP_PROG, 20'h01FFF, 16'h5A5A, 16'h0000);
      chk(16'(took < 70), 16'h0001);
      op(FCS_OP_READ, 20'h01FFF, 16'h0000, 16'hFFFF);
      op(FCS_OP_PROG, 20'h02000, 16'h5A5A, 16'h0000);
      op(FCS_OP_CHIP, 20'h00000, 16'h0000, 16'h0000);
      op(FCS_OP_READ, 20'h02000, 16'h0000, 16'h5A5A);
      wp_n = 1;
      op(FCS_OP_PROG, 20'h01FFF, 16'h5A5A, 16'h0000);
      op(FCS_OP_READ, 20'h01FFF, 16'h0000, 16'h5A5A);
      op(FCS_OP_SECTOR, 20'h40000, 16'h0000, 16'h0000);
      op(FCS_OP_READ, 20'h40010, 16'h0000, 16'hFFFF);
      op(FCS_OP_READ, 20'h40810, 16'h0000, 16'h0F0F);
      op(FCS_OP_BLOCK, 20'h47FFF, 16'h0000, 16'h0000);
      op(FCS_OP_READ, 20'h40810, 16'h0000, 16'hFFFF);
      op(FCS_OP_PROG, 20'h48000, 16'hA5C3, 16'h0000);
      byte_mode = 1;
      op(FCS_OP_READ, 20'h48000, 16'h0000, 16'h00C3);
      chk(16'(byte_n), 16'h0000);
      byte_mode = 0;
      op(FCS_OP_CHIP, 20'h00000, 16'h0000, 16'h0000);
      op(FCS_OP_READ, 20'h02000, 16'h0000, 16'hFFFF);
      flash_reset_req = 1;
      repeat (2) @(negedge core_clk);
      chk(16'(flash_rst_n), 16'h0000);
      flash_reset_req = 0;
      chk(16'(flash_u.bad), 16'h0000);
      results();
   end
endmodule
